// *** rtl/scip_pkg.sv ***
// Shared types and constants for the slave/cascade interrupt pin block
package scip_pkg;

  localparam int SCIP_NUM_REQ = 5;
  localparam int SCIP_LINE_ZERO = 0;
  localparam int SCIP_LINE_ONE = 1;
  localparam int SCIP_LINE_TWO = 2;
  localparam int SCIP_LINE_THREE = 3;
  localparam int SCIP_LINE_FOUR = 4;
  localparam logic [4:0] SCIP_REQ_RST = 5'h00;
  localparam logic [1:0] SCIP_SYNC_RST = 2'h0;

  typedef enum logic [1:0] {
    SCIP_MODE_MASTER,
    SCIP_MODE_CASCADE,
    SCIP_MODE_SFNM,
    SCIP_MODE_SLAVE
  } scip_mode_t;

  // Pin mode selection per shared pin
  typedef struct packed {
    logic pio_line_one;
    logic pio_line_two;
    logic pio_line_three;
  } scip_pio_sel_t;

  // Values driven onto one two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } scip_pin_drv_t;

  typedef enum logic [1:0] {
    SCIP_SL_IDLE,
    SCIP_SL_REQ,
    SCIP_SL_TYPE
  } scip_sl_state_t;

endpackage : scip_pkg

// *** rtl/scip_edge.sv ***
// Per-line request register with level and edge capture
module scip_edge
  import scip_pkg::*;
#(
  parameter int WIDTH = SCIP_NUM_REQ
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_req,
  input wire logic [WIDTH-1:0] i_gate,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise
);

  if (WIDTH < 1) begin : g_bad_width
    $error("scip_edge: WIDTH must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] lvl;
  } scip_edge_st_t;

  scip_edge_st_t st_r;
  scip_edge_st_t st_nxt;
  logic [WIDTH-1:0] gated;

  // Same treatment for every line; only position differs
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_line
      assign gated[g] = i_req[g] & i_gate[g];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.lvl = gated;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_level = st_r.lvl;
  assign o_rise = gated & ~st_r.lvl;

endmodule : scip_edge

// *** rtl/scip_pins.sv ***
// Interrupt request, acknowledge and slave-select pin logic
// What this block does
// - In slave mode the shared request pin drives a request to the master.
// - Cascade or fully-nested: pin shared with line two is line zero's ack.
// - Cascade or fully-nested: pin shared with line three is line one's ack.
// - In master mode, lines one and two behave like line four, own line and vector.
// - Line zero is maskable and behaves like line four.
// - Slave-select input after line zero means an interrupt type is on the bus.
// - Enabled port data register turns multiplexed pins into port bits.
module scip_pins
  import scip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire scip_mode_t i_mode,
  input wire logic i_pio_data_en,
  input wire scip_pio_sel_t i_pio_sel,
  input wire logic [SCIP_NUM_REQ-1:0] i_mask,
  input wire logic i_ext_req_line_zero,
  input wire logic i_ext_req_line_one_in,
  input wire logic i_ext_req_line_two_in,
  input wire logic i_line_three_in,
  input wire logic i_ext_req_line_four,
  input wire logic [SCIP_NUM_REQ-1:0] i_ack_pulse,
  input wire logic i_slave_req,
  input wire logic i_pio_line_one_out,
  input wire logic i_pio_line_two_out,
  input wire logic i_pio_line_three_out,
  input wire logic [2:0] i_pio_oe,
  output logic o_ext_req_line_one_out,
  output logic o_ext_req_line_one_oe,
  output logic o_ack_out_zero,
  output logic o_ack_out_zero_oe,
  output logic o_ack_out_one,
  output logic o_ack_out_one_oe,
  output logic [SCIP_NUM_REQ-1:0] o_pending,
  output logic [SCIP_NUM_REQ-1:0] o_req_edge,
  output logic o_type_on_bus,
  output logic o_select_err,
  output logic [2:0] o_port_in
);

  typedef struct packed {
    logic [SCIP_NUM_REQ-1:0] pend;
    logic ack0;
    logic ack1;
    logic irq;
    logic type_bus;
    logic sel_err;
    logic [2:0] port_in;
    scip_sl_state_t sl;
  } scip_st_t;

  // What each shared pin is doing in the current mode
  typedef enum logic [2:0] {
    SCIP_ROLE_REQ,
    SCIP_ROLE_PORT,
    SCIP_ROLE_ACK,
    SCIP_ROLE_SELECT,
    SCIP_ROLE_IRQ
  } scip_role_t;

  scip_st_t st_r;
  scip_st_t st_nxt;
  logic casc;
  logic slave;
  logic pio1;
  logic pio2;
  logic pio3;
  logic [SCIP_NUM_REQ-1:0] raw;
  logic [SCIP_NUM_REQ-1:0] gate;
  logic [SCIP_NUM_REQ-1:0] lvl;
  logic [SCIP_NUM_REQ-1:0] rise;
  logic select_act;
  scip_role_t role_one;
  scip_role_t role_two;
  scip_role_t role_three;

  assign casc = (i_mode == SCIP_MODE_CASCADE) || (i_mode == SCIP_MODE_SFNM);
  assign slave = (i_mode == SCIP_MODE_SLAVE);
  // Port mode only takes effect with the data register enabled
  assign pio1 = i_pio_data_en & i_pio_sel.pio_line_one;
  assign pio2 = i_pio_data_en & i_pio_sel.pio_line_two;
  assign pio3 = i_pio_data_en & i_pio_sel.pio_line_three;

  // One role per shared pin keeps gating and drivers in step
  always_comb begin
    if (pio1) begin
      role_one = SCIP_ROLE_PORT;
    end else if (slave) begin
      role_one = SCIP_ROLE_SELECT;
    end else begin
      role_one = SCIP_ROLE_REQ;
    end
    if (pio2) begin
      role_two = SCIP_ROLE_PORT;
    end else if (casc) begin
      role_two = SCIP_ROLE_ACK;
    end else begin
      role_two = SCIP_ROLE_REQ;
    end
    if (pio3) begin
      role_three = SCIP_ROLE_PORT;
    end else if (casc) begin
      role_three = SCIP_ROLE_ACK;
    end else if (slave) begin
      role_three = SCIP_ROLE_IRQ;
    end else begin
      role_three = SCIP_ROLE_REQ;
    end
  end

  // Line one pin doubles as slave select (active low) in slave mode
  assign select_act = (role_one == SCIP_ROLE_SELECT) &
                      ~i_ext_req_line_one_in;

  always_comb begin
    raw = '0;
    raw[SCIP_LINE_ZERO] = i_ext_req_line_zero;
    raw[SCIP_LINE_ONE] = i_ext_req_line_one_in;
    raw[SCIP_LINE_TWO] = i_ext_req_line_two_in;
    raw[SCIP_LINE_THREE] = i_line_three_in;
    raw[SCIP_LINE_FOUR] = i_ext_req_line_four;
    gate = ~i_mask;
    // Port, ack, select and irq pins never raise requests
    gate[SCIP_LINE_ONE] &= (role_one == SCIP_ROLE_REQ);
    gate[SCIP_LINE_TWO] &= (role_two == SCIP_ROLE_REQ);
    gate[SCIP_LINE_THREE] &= (role_three == SCIP_ROLE_REQ);
  end

  scip_edge #(
    .WIDTH(SCIP_NUM_REQ)
  ) u_edge (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_req(raw),
    .i_gate(gate),
    .o_level(lvl),
    .o_rise(rise)
  );

  always_comb begin
    st_nxt = st_r;
    // Pending: set wins over the acknowledge clear
    st_nxt.pend = (st_r.pend & ~i_ack_pulse) | rise;
    st_nxt.ack0 = (role_two == SCIP_ROLE_ACK) &
                  i_ack_pulse[SCIP_LINE_ZERO];
    st_nxt.ack1 = (role_three == SCIP_ROLE_ACK) &
                  i_ack_pulse[SCIP_LINE_ONE];
    st_nxt.irq = (role_three == SCIP_ROLE_IRQ) & i_slave_req;
    st_nxt.sel_err = 1'b0;
    st_nxt.port_in = {i_line_three_in, i_ext_req_line_two_in,
                      i_ext_req_line_one_in};
    case (st_r.sl)
      SCIP_SL_IDLE: begin
        st_nxt.type_bus = 1'b0;
        if (slave && lvl[SCIP_LINE_ZERO]) begin
          st_nxt.sl = SCIP_SL_REQ;
        end else if (select_act) begin
          // Select ahead of line zero breaks the master's ordering
          st_nxt.sel_err = 1'b1;
        end
      end
      SCIP_SL_REQ: begin
        if (!slave) begin
          st_nxt.sl = SCIP_SL_IDLE;
        end else if (select_act) begin
          st_nxt.sl = SCIP_SL_TYPE;
          st_nxt.type_bus = 1'b1;
        end else if (!lvl[SCIP_LINE_ZERO]) begin
          st_nxt.sl = SCIP_SL_IDLE;
        end
      end
      SCIP_SL_TYPE: begin
        st_nxt.type_bus = select_act;
        if (!select_act) begin
          st_nxt.sl = SCIP_SL_IDLE;
        end
      end
      default: begin
        st_nxt.sl = SCIP_SL_IDLE;
        st_nxt.type_bus = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '{pend: SCIP_REQ_RST, ack0: 1'b0, ack1: 1'b0, irq: 1'b0,
                type_bus: 1'b0, sel_err: 1'b0, port_in: 3'h0,
                sl: SCIP_SL_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Acks are active low on the pin; an undriven ack pin rests high, the line one pin rests low
  always_comb begin
    case (role_one)
      SCIP_ROLE_PORT: begin
        o_ext_req_line_one_out = i_pio_line_one_out;
        o_ext_req_line_one_oe = i_pio_oe[0];
      end
      default: begin
        // Request or select input: never driven
        o_ext_req_line_one_out = 1'b0;
        o_ext_req_line_one_oe = 1'b0;
      end
    endcase
    case (role_two)
      SCIP_ROLE_PORT: begin
        o_ack_out_zero = i_pio_line_two_out;
        o_ack_out_zero_oe = i_pio_oe[1];
      end
      SCIP_ROLE_ACK: begin
        o_ack_out_zero = ~st_r.ack0;
        o_ack_out_zero_oe = 1'b1;
      end
      default: begin
        o_ack_out_zero = 1'b1;
        o_ack_out_zero_oe = 1'b0;
      end
    endcase
    case (role_three)
      SCIP_ROLE_PORT: begin
        o_ack_out_one = i_pio_line_three_out;
        o_ack_out_one_oe = i_pio_oe[2];
      end
      SCIP_ROLE_ACK: begin
        o_ack_out_one = ~st_r.ack1;
        o_ack_out_one_oe = 1'b1;
      end
      SCIP_ROLE_IRQ: begin
        o_ack_out_one = st_r.irq;
        o_ack_out_one_oe = 1'b1;
      end
      default: begin
        o_ack_out_one = 1'b1;
        o_ack_out_one_oe = 1'b0;
      end
    endcase
  end

  assign o_pending = st_r.pend;
  assign o_req_edge = rise;
  assign o_type_on_bus = st_r.type_bus;
  assign o_select_err = st_r.sel_err;
  assign o_port_in = st_r.port_in;

endmodule : scip_pins

// *** tb/scip_master_model.sv ***
// Master controller model: line zero then active-low slave select
module scip_master_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic i_bad,
  output logic o_line_zero,
  output logic o_select_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic bad_r = 1'b0;
  int n = 0;
  always @(posedge i_sys_clk) begin
    if (i_go || i_bad) begin
      n <= 5;
      bad_r <= i_bad;
    end else if (n > 0) begin
      n <= n - 1;
    end
  end
  // Select lags line zero one cycle; bad frames skip line zero
  assign o_line_zero = n > 0 && !bad_r;
  assign o_select_n = !(n > 0 && n < 5);
endmodule // scip_master_model

// *** tb/scip_pins_monitor.sv ***
// Port-level checker for the interrupt pin block
module scip_pins_monitor
  import scip_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire scip_mode_t i_mode,
  input wire logic i_pio_data_en,
  input wire scip_pio_sel_t i_pio_sel,
  input wire logic [SCIP_NUM_REQ-1:0] i_mask,
  input wire logic [SCIP_NUM_REQ-1:0] i_ack_pulse,
  input wire logic i_slave_req,
  input wire logic i_ext_req_line_one_in,
  input wire logic [2:0] i_pio_oe,
  input wire logic o_ext_req_line_one_oe,
  input wire logic o_ack_out_zero,
  input wire logic o_ack_out_one,
  input wire logic [SCIP_NUM_REQ-1:0] o_pending,
  input wire logic [SCIP_NUM_REQ-1:0] o_req_edge,
  input wire logic o_type_on_bus
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  wire p1 = i_pio_data_en & i_pio_sel.pio_line_one;
  wire p2 = i_pio_data_en & i_pio_sel.pio_line_two;
  wire p3 = i_pio_data_en & i_pio_sel.pio_line_three;
  wire sl = i_mode == SCIP_MODE_SLAVE;
  // Cascade or nested mode
  wire cs = i_mode[0] ^ i_mode[1];
  a_slave_irq_out: assert property (
    sl && !p3 && i_slave_req ##1 sl && !p3 |-> o_ack_out_one)
    else $error("irq pin low");
  a_ack_zero_pin: assert property (
    cs && !p2 && i_ack_pulse[0] ##1 cs && !p2 |-> !o_ack_out_zero)
    else $error("ack zero missing");
  a_ack_one_pin: assert property (
    cs && !p3 && i_ack_pulse[1] ##1 cs && !p3 |-> !o_ack_out_one)
    else $error("ack one missing");
  a_edge_sets_pend: assert property (o_req_edge[2] |=> o_pending[2])
    else $error("pending not set");
  a_mask_zero: assert property (i_mask[0] |-> !o_req_edge[0])
    else $error("masked edge");
  a_select_type: assert property ($rose(o_type_on_bus)
    |-> $past(sl && !i_ext_req_line_one_in)) else $error("type without select");
  a_port_oe_pass: assert property (
    p1 |-> o_ext_req_line_one_oe == i_pio_oe[0])
    else $error("port enable wrong");
  a_port_no_req: assert property (p2 |-> !o_req_edge[2])
    else $error("port pin requested");
endmodule // scip_pins_monitor

// *** tb/tb.sv ***
// Self-checking bench for the interrupt pin block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import scip_pkg::*;
  logic i_sys_clk = 0, i_resetn = 0, i_pio_data_en = 0, i_slave_req = 0;
  logic i_ext_req_line_zero, i_ext_req_line_one_in, i_ext_req_line_two_in;
  logic i_line_three_in, i_ext_req_line_four, go = 0, bad = 0, l0, sel_n;
  logic i_pio_line_one_out = 1, i_pio_line_two_out = 0;
  logic i_pio_line_three_out = 1, o_ext_req_line_one_out;
  logic [2:0] i_pio_oe = 3'h5, o_port_in;
  logic [4:0] i_mask = 5'h00, i_ack_pulse = 5'h00, req = 5'h00;
  logic [4:0] o_pending, o_req_edge;
  logic o_ext_req_line_one_oe, o_ack_out_zero, o_ack_out_zero_oe;
  logic o_ack_out_one, o_ack_out_one_oe, o_type_on_bus, o_select_err;
  scip_mode_t i_mode = SCIP_MODE_MASTER;
  scip_pio_sel_t i_pio_sel = '0;
  int n_fail = 0, comparisons = 0;
  wire sl = i_mode == SCIP_MODE_SLAVE;
  assign i_ext_req_line_zero = sl ? l0 : req[0];
  assign i_ext_req_line_one_in = sl ? sel_n : req[1];
  assign {i_ext_req_line_four, i_line_three_in, i_ext_req_line_two_in} =
    {req[4], req[3], req[2]};
  scip_pins dut_u (.*);
  scip_master_model mm_u (.i_sys_clk(i_sys_clk), .i_go(go), .i_bad(bad),
    .o_line_zero(l0), .o_select_n(sel_n));
  task cyc(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task chk(string s, logic [5:0] e, logic [5:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  initial begin
    #5000;
    n_fail++;
    wrap_up;
  end
  initial begin
    cyc(12);
    i_resetn = 1;
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 5; k++) begin
        i_mask = m ? 5'h1F : 5'h00;
        req = 5'h01 << k;
        #1;
        chk("edge", m ? 6'h00 : 6'h01 << k, o_req_edge);
        cyc(3);
        chk("pending", m ? 6'h00 : 6'h01 << k, o_pending);
        i_ack_pulse = req;
        cyc(1);
        i_ack_pulse = 5'h00;
        req = 5'h00;
        cyc(1);
        chk("cleared", 6'h00, o_pending);
      end
    i_mask = 5'h00;
    $display("test requests done");
    for (int m = 1; m < 3; m++)
      for (int b = 0; b < 2; b++) begin
        i_mode = scip_mode_t'(m);
        i_ack_pulse = 5'h01 << b;
        cyc(1);
        i_ack_pulse = 5'h00;
        chk("ack pins", b ? 6'h01 : 6'h02,
          {o_ack_out_one, o_ack_out_zero});
        chk("ack oe", 6'h03, {o_ack_out_one_oe, o_ack_out_zero_oe});
        cyc(1);
      end
    $display("test acknowledge done");
    i_mode = SCIP_MODE_SLAVE;
    go = 1;
    cyc(1);
    go = 0;
    repeat (8) if (o_type_on_bus !== 1'b1) cyc(1);
    chk("type on bus", 6'h01, o_type_on_bus);
    cyc(6);
    bad = 1;
    cyc(1);
    bad = 0;
    repeat (8) if (o_select_err !== 1'b1) cyc(1);
    chk("select err", 6'h01, o_select_err);
    i_slave_req = 1;
    cyc(2);
    chk("irq out", 6'h01, o_ack_out_one);
    i_slave_req = 0;
    $display("test slave done");
    i_ack_pulse = 5'h1F;
    i_mode = SCIP_MODE_MASTER;
    i_pio_data_en = 1;
    i_pio_sel = '1;
    req = 5'h04;
    cyc(1);
    i_ack_pulse = 5'h00;
    cyc(3);
    chk("port pins", 6'h33, {o_ext_req_line_one_out, o_ext_req_line_one_oe,
      o_ack_out_zero, o_ack_out_zero_oe, o_ack_out_one, o_ack_out_one_oe});
    chk("port req", 6'h00, o_pending);
    chk("port in", 6'h02, o_port_in);
    $display("test port done");
    wrap_up;
  end
endmodule // tb
bind scip_pins scip_pins_monitor mon_u (.*);
